// ===== hw/rf_stream_pkg.sv
// Constants, register layout and state types of the stream-mode framer
package rf_stream_pkg;
   // ==========================================================
   // Register offsets (6-bit address space)
   localparam logic [5:0] ADDR_IO_ONE     = 6'h00;
   localparam logic [5:0] ADDR_IO_TWO     = 6'h01;
   localparam logic [5:0] ADDR_OP_CTRL    = 6'h02;
   localparam logic [5:0] ADDR_MODE_DEF   = 6'h03;
   localparam logic [5:0] ADDR_TYPE_A     = 6'h05;
   localparam logic [5:0] ADDR_STREAM_OPT = 6'h08;
   localparam logic [5:0] ADDR_STATUS     = 6'h30;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_IO_ONE     = 8'h08;
   localparam logic [7:0] RST_IO_TWO     = 8'h00;
   localparam logic [7:0] RST_OP_CTRL    = 8'h00;
   localparam logic [7:0] RST_MODE_DEF   = 8'h00;
   localparam logic [7:0] RST_TYPE_A     = 8'h00;
   localparam logic [7:0] RST_STREAM_OPT = 8'h00;
   // ==========================================================
   // Field positions and codes
   localparam int         OP_RX_EN_BIT = 6;
   localparam int         OM_LSB       = 3;
   localparam logic [3:0] OM_SUBC      = 4'hE;
   localparam logic [3:0] OM_BPSK      = 4'hF;
   localparam int         SCF_LSB      = 5;
   localparam int         SCP_LSB      = 3;
   localparam int         STX_LSB      = 0;
   localparam int         OOK_BIT      = 7;
   localparam int         TA_CUST_LSB  = 6;
   // ==========================================================
   // Counts in carrier cycles (one CLK_SYS edge per fc cycle); SUBC_END_IDLE counts empty periods
   localparam logic [9:0] SUBC_BASE_PER  = 10'h040;
   localparam logic [9:0] BPSK_BASE_PER  = 10'h010;
   localparam logic [7:0] TX_BASE_PER    = 8'h80;
   localparam logic [3:0] SUBC_END_IDLE  = 4'h8;

   typedef struct packed {
      logic [7:0] io_one;
      logic [7:0] io_two;
      logic [7:0] op_ctrl;
      logic [7:0] mode_def;
      logic [7:0] type_a;
      logic [7:0] stream_opt;
   } regs_s;

   localparam regs_s REGS_RST = '{RST_IO_ONE, RST_IO_TWO, RST_OP_CTRL,
      RST_MODE_DEF, RST_TYPE_A, RST_STREAM_OPT};

   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_LOAD = 3'b010,
      TX_SEND = 3'b100
   } tx_state_e;

   typedef struct packed {
      regs_s      regs;
      logic [1:0] sync;
      logic       sub_prev;
      logic [9:0] per_cnt;
      logic       seen;
      logic       phase_smp;
      logic       ph_ref;
      logic       rx_act;
      logic [3:0] idle_cnt;
      logic [7:0] sh;
      logic [2:0] nb;
      logic [7:0] rx_data;
      logic       rx_valid;
      logic       rx_start;
      logic       rx_end;
      tx_state_e  tx;
      logic [7:0] tx_sh;
      logic [2:0] tx_idx;
      logic [7:0] tx_cnt;
      logic       tx_mod;
      logic       tx_pop;
      logic [7:0] rdata;
   } state_s;
endpackage : rf_stream_pkg

// ===== hw/rf_stream_mode_framer.sv
// Stream-mode framer: sub-carrier/BPSK receive and bit-timed transmit
// Behaviour
// [R1] First bit sent or received sits in the FIFO byte's LSB.
// [R2] Mode register selects stream operation; stream options register sets it.
// [R3] Host configures receiver and transmitter itself; analog preset ignored.
// [R4] Sub-carrier receive accepts fc/64 up to fc/8.
// [R5] Sub-carrier reporting period spans two to eight sub-carrier periods.
// [R6] First period with sub-carrier raises start event and stores first bit.
// [R7] Sub-carrier mode stores 1 for sub-carrier seen, 0 otherwise.
// [R8] Sub-carrier mode ends after more than eight empty periods.
// [R9] Sub-carrier scf 01b is fc/32; scp 10b is four periods.
// [R10] BPSK receive accepts fc/16 up to fc/4.
// [R11] BPSK reporting period spans one to eight sub-carrier periods.
// [R12] BPSK stores 0 for initial phase, 1 for inverted phase.
// [R13] BPSK ends at first period without sub-carrier.
// [R14] BPSK scf 01b is fc/8; scp 01b is two periods.
// [R15] Each transmit bit holds modulation for one Tx period; 1 modulates.
// [R16] Tx period code 000b means 128 carrier cycles.
// [R17] Either transmit command starts sending the stream.
// [R18] Type A register bits six and seven enable custom frames.
// [R19] Registers use 6-bit addresses 00h to 3Fh.
// [R20] Configuration registers read/write; display registers read-only state.
// [R21] Set default resets registers except IO config and operation control.
// [R22] Received bits pack LSB-first; byte commits at eight bits or end.
// [R23] Registers are eight bits; writes to display registers are ignored.
`timescale 1ns/1ps
module rf_stream_mode_framer
   import rf_stream_pkg::*;
(
   // Clock and power-up reset
   input  wire logic       CLK_SYS,
   input  wire logic       RST,
   // Register port
   input  wire logic [5:0] REG_ADDR,
   input  wire logic       REG_WE,
   input  wire logic [7:0] REG_WDATA,
   output logic      [7:0] REG_RDATA,
   // Direct commands
   input  wire logic       CMD_SET_DEFAULT,
   input  wire logic       CMD_TX_NOCRC,
   input  wire logic       CMD_TX_CRC,
   // Demodulated sub-carrier pin
   input  wire logic       SUBC_IN,
   // Receive FIFO side
   output logic      [7:0] RX_DATA,
   output logic            RX_VALID,
   output logic            RX_START,
   output logic            RX_END,
   // Transmit FIFO side (show-ahead head word)
   input  wire logic [7:0] TX_DATA,
   input  wire logic       TX_AVAIL,
   output logic            TX_POP,
   // Modulator control
   output logic            TX_MOD,
   output logic            TX_OOK,
   output logic      [1:0] TYPE_A_CUSTOM
);
   state_s     q;
   state_s     d;
   logic [3:0] om;
   logic       subm;
   logic       bpm;
   logic       strm;
   logic [1:0] scf;
   logic [1:0] scp;
   logic [2:0] stx;
   logic [9:0] subper;
   logic [9:0] per_len;
   logic       per_end;
   logic       edge_s;
   logic       hit;
   logic       rx_run;
   logic [7:0] tx_len;

   // ==========================================================
   // Mode decode
   assign om     = q.regs.mode_def[OM_LSB +: 4];                      // [R2]
   assign subm   = (om == OM_SUBC);
   assign bpm    = (om == OM_BPSK);
   assign strm   = subm | bpm;
   assign scf    = q.regs.stream_opt[SCF_LSB +: 2];
   assign scp    = q.regs.stream_opt[SCP_LSB +: 2];
   assign stx    = q.regs.stream_opt[STX_LSB +: 3];
   // Sub-carrier period: fc/64..fc/8 or fc/16..fc/4
   assign subper = subm ? (SUBC_BASE_PER >> scf)                   // [R4] [R9]
      : (BPSK_BASE_PER >> ((scf == 2'h3) ? 2'h2 : scf));         // [R10] [R14]
   // Sub-carrier mode has no single-period code: 00b falls back to two
   assign per_len = subper << ((subm && scp == 2'h0) ? 2'h1 : scp);
                                                      // [R5] [R9] [R11] [R14]
   assign per_end = (q.per_cnt == per_len - 10'h001);
   assign edge_s  = q.sync[1] & ~q.sub_prev;
   assign hit     = q.seen | edge_s;
   // Receiver listens only while the transmitter is idle
   assign rx_run  = strm & q.regs.op_ctrl[OP_RX_EN_BIT] & (q.tx == TX_IDLE);
   assign tx_len  = TX_BASE_PER >> stx;                                // [R16]

   // ==========================================================
   // Next state
   always_comb begin
      logic st;
      logic bv;
      logic fin;
      logic fetch;
      logic [7:0] nsh;
      st    = 1'b0;
      bv    = 1'b0;
      fin   = 1'b0;
      fetch = 1'b0;
      nsh   = q.sh;
      d          = q;
      d.rx_valid = 1'b0;
      d.rx_start = 1'b0;
      d.rx_end   = 1'b0;
      d.tx_pop   = 1'b0;
      // Only the second stage is read by the receive logic
      d.sync     = {q.sync[0], SUBC_IN};
      d.sub_prev = q.sync[1];

      // Receive framing
      if (!rx_run) begin
         d.per_cnt = 10'h000;
         d.seen    = 1'b0;
         d.rx_act  = 1'b0;
         // Partial byte dropped so the next frame starts at the LSB
         d.sh      = 8'h00;                                            // [R1]
         d.nb      = 3'h0;
      end else begin
         d.per_cnt = per_end ? 10'h000 : q.per_cnt + 10'h001;
         if (edge_s) begin
            d.seen = 1'b1;
         end
         // Phase probe a quarter sub-carrier period into each period
         if (q.per_cnt == (subper >> 2)) begin
            d.phase_smp = q.sync[1];
         end
         if (per_end) begin
            d.seen = 1'b0;
            if (!q.rx_act) begin
               if (hit) begin
                  d.rx_act   = 1'b1;
                  d.rx_start = 1'b1;                                   // [R6]
                  d.ph_ref   = q.phase_smp;
                  d.idle_cnt = 4'h0;
                  st = 1'b1;
                  bv = subm;                                       // [R7] [R12]
               end
            end else if (bpm) begin
               if (!hit) begin
                  fin = 1'b1;                                         // [R13]
               end else begin
                  st = 1'b1;
                  bv = q.phase_smp ^ q.ph_ref;                        // [R12]
               end
            end else if (hit) begin
               d.idle_cnt = 4'h0;
               st = 1'b1;
               bv = 1'b1;                                              // [R7]
            end else if (q.idle_cnt == SUBC_END_IDLE) begin
               fin = 1'b1;                                             // [R8]
            end else begin
               d.idle_cnt = q.idle_cnt + 4'h1;
               st = 1'b1;
               bv = 1'b0;                                              // [R7]
            end
         end
      end
      if (st) begin
         nsh[q.nb] = bv;                                              // [R1]
         d.sh = nsh;
         d.nb = q.nb + 3'h1;
         if (q.nb == 3'h7) begin
            d.rx_data  = nsh;                                         // [R22]
            d.rx_valid = 1'b1;
            d.sh       = 8'h00;
         end
      end
      if (fin) begin
         d.rx_act = 1'b0;
         d.rx_end = 1'b1;
         d.sh     = 8'h00;
         d.nb     = 3'h0;
         if (q.nb != 3'h0) begin
            d.rx_data  = q.sh;                                        // [R22]
            d.rx_valid = 1'b1;
         end
      end

      // Transmit sequencing
      case (q.tx)
         TX_IDLE: begin
            if ((CMD_TX_NOCRC | CMD_TX_CRC) && strm) begin
               d.tx = TX_LOAD;                                        // [R17]
            end
         end
         TX_LOAD: begin
            fetch = 1'b1;
         end
         TX_SEND: begin
            d.tx_cnt = q.tx_cnt + 8'h01;
            if (q.tx_cnt == tx_len - 8'h01) begin
               d.tx_cnt = 8'h00;
               d.tx_idx = q.tx_idx + 3'h1;
               d.tx_mod = q.tx_sh[q.tx_idx + 3'h1];                   // [R15]
               if (q.tx_idx == 3'h7) begin
                  fetch = 1'b1;
               end
            end
         end
         default: begin
            d.tx = TX_IDLE;
         end
      endcase
      if (fetch) begin
         d.tx_cnt = 8'h00;
         d.tx_idx = 3'h0;
         if (TX_AVAIL) begin
            d.tx_sh  = TX_DATA;
            d.tx_pop = 1'b1;
            d.tx_mod = TX_DATA[0];                               // [R1] [R15]
            d.tx     = TX_SEND;
         end else begin
            d.tx_mod = 1'b0;
            d.tx     = TX_IDLE;
         end
      end

      // Register writes; status is read-only
      if (REG_WE) begin
         case (REG_ADDR)                                               // [R19]
            ADDR_IO_ONE:     d.regs.io_one     = REG_WDATA;            // [R20]
            ADDR_IO_TWO:     d.regs.io_two     = REG_WDATA;
            ADDR_OP_CTRL:    d.regs.op_ctrl    = REG_WDATA;
            ADDR_MODE_DEF:   d.regs.mode_def   = REG_WDATA;
            ADDR_TYPE_A:     d.regs.type_a     = REG_WDATA;
            ADDR_STREAM_OPT: d.regs.stream_opt = REG_WDATA;
            default:         d.regs = q.regs;                          // [R23]
         endcase
      end
      // Set default outranks a write in the same cycle
      if (CMD_SET_DEFAULT) begin
         d.regs.mode_def   = RST_MODE_DEF;                             // [R21]
         d.regs.type_a     = RST_TYPE_A;
         d.regs.stream_opt = RST_STREAM_OPT;
      end

      case (REG_ADDR)
         ADDR_IO_ONE:     d.rdata = q.regs.io_one;
         ADDR_IO_TWO:     d.rdata = q.regs.io_two;
         ADDR_OP_CTRL:    d.rdata = q.regs.op_ctrl;
         ADDR_MODE_DEF:   d.rdata = q.regs.mode_def;
         ADDR_TYPE_A:     d.rdata = q.regs.type_a;
         ADDR_STREAM_OPT: d.rdata = q.regs.stream_opt;
         ADDR_STATUS:     d.rdata = {q.rx_act, q.tx != TX_IDLE,
                                     3'h0, q.nb};                      // [R20]
         default:         d.rdata = 8'h00;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         q      <= '0;
         q.regs <= REGS_RST;                                          // [R21]
         q.tx   <= TX_IDLE;
      end else begin
         q <= d;
      end
   end

   assign REG_RDATA     = q.rdata;
   assign RX_DATA       = q.rx_data;
   assign RX_VALID      = q.rx_valid;
   assign RX_START      = q.rx_start;
   assign RX_END        = q.rx_end;
   assign TX_POP        = q.tx_pop;
   assign TX_MOD        = q.tx_mod;
   assign TX_OOK        = q.regs.stream_opt[OOK_BIT];
   assign TYPE_A_CUSTOM = q.regs.type_a[TA_CUST_LSB +: 2];            // [R18]

   // ==========================================================
   // Checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   property p_start_lsb;
      rx_run && subm && !q.rx_act && per_end && hit
         |=> RX_START && q.sh[0] && q.nb == 3'h1;
   endproperty
   a_start_lsb: assert property (p_start_lsb)          // [R1] [R6] [R7]
      else $error("start bit not stored in lsb");
   property p_sub_end;
      rx_run && subm && q.rx_act && per_end && !hit
         && q.idle_cnt == 4'h8 |=> RX_END;
   endproperty
   a_sub_end: assert property (p_sub_end)                            // [R8]
      else $error("sub-carrier end missing");
   property p_sub_noend;
      rx_run && subm && q.rx_act && per_end && q.idle_cnt < 4'h8
         |=> !RX_END;
   endproperty
   a_sub_noend: assert property (p_sub_noend)                        // [R8]
      else $error("sub-carrier end too early");
   property p_bpsk_end;
      rx_run && bpm && q.rx_act && per_end && !hit |=> RX_END;
   endproperty
   a_bpsk_end: assert property (p_bpsk_end)                         // [R13]
      else $error("bpsk end missing");
   property p_byte_commit;
      rx_run && q.rx_act && per_end && q.nb == 3'h7
         |=> RX_VALID && q.nb == 3'h0;
   endproperty
   a_byte_commit: assert property (p_byte_commit)                   // [R22]
      else $error("full byte not committed");
   property p_tx_hold;
      q.tx == TX_SEND && stx == 3'h0 && q.tx_cnt != 8'h7F
         |=> $stable(TX_MOD);
   endproperty
   a_tx_hold: assert property (p_tx_hold)                     // [R15] [R16]
      else $error("tx bit changed inside its period");
   property p_tx_cmd;
      q.tx == TX_IDLE && strm && CMD_TX_CRC |=> q.tx == TX_LOAD;
   endproperty
   a_tx_cmd: assert property (p_tx_cmd)                             // [R17]
      else $error("transmit command not taken");
   property p_set_default;
      CMD_SET_DEFAULT && !REG_WE |=> q.regs.mode_def == RST_MODE_DEF
         && q.regs.stream_opt == RST_STREAM_OPT
         && q.regs.io_one == $past(q.regs.io_one)
         && q.regs.op_ctrl == $past(q.regs.op_ctrl);
   endproperty
   a_set_default: assert property (p_set_default)                  // [R21]
      else $error("set default wrong");
   property p_read_mode;
      REG_ADDR == ADDR_MODE_DEF |=> REG_RDATA == $past(q.regs.mode_def);
   endproperty
   a_read_mode: assert property (p_read_mode)                      // [R20]
      else $error("mode register readback wrong");
   property p_status_ro;
      REG_WE && REG_ADDR == ADDR_STATUS && !CMD_SET_DEFAULT
         |=> q.regs == $past(q.regs);
   endproperty
   a_status_ro: assert property (p_status_ro)                      // [R23]
      else $error("status write changed a register");

   c_sub_rx: cover property (subm && RX_START ##[1:900] RX_END);
   c_bpsk_rx: cover property (bpm && RX_START ##[1:200] RX_END);
   c_tx_byte: cover property (TX_POP ##[1:1000] TX_POP);
endmodule : rf_stream_mode_framer

// ===== tb/rf_tag_model.sv
// Contactless tag model: sub-carrier bursts or BPSK answer on the line
`timescale 1ns/1ps
module rf_tag_model (
   // Timing
   input  wire logic        clk,
   input  wire logic        go,
   // Frame shape
   input  wire logic        bpsk,
   input  wire logic [7:0]  half,
   input  wire logic [7:0]  per,
   input  wire logic [15:0] bits,
   input  wire logic [4:0]  nbits,
   // Demodulated sub-carrier line
   output logic             subc
);
   int   k;
   int   t;
   logic sq;
   logic win;

   initial begin
      subc = 1'b0;
      forever begin
         @(posedge clk);
         if (go) begin
            for (k = 0; k < nbits; k++) begin
               for (t = 0; t < per; t++) begin
                  @(negedge clk);
                  sq  = ((t / half) % 2) == 0;
                  // Burst kept mid-period so frame skew cannot split a bit
                  win = t >= per / 4 && t < 3 * per / 4;
                  if (bpsk)
                     subc = sq ^ bits[k];
                  else
                     subc = bits[k] & win & sq;
               end
            end
            @(negedge clk);
            subc = 1'b0;
         end
      end
   end
endmodule : rf_tag_model

// ===== tb/rf_stream_mode_framer_bench.sv
// Self-checking bench of the stream-mode framer
`timescale 1ns/1ps
module rf_stream_mode_framer_bench;
   import rf_stream_pkg::*;
   // ==========================================================
   // Signals
   logic        CLK_SYS, RST, REG_WE, CMD_SET_DEFAULT;
   logic        CMD_TX_NOCRC, CMD_TX_CRC, SUBC_IN, TX_AVAIL;
   logic        RX_VALID, RX_START, RX_END, TX_POP, TX_MOD, TX_OOK;
   logic [5:0]  REG_ADDR;
   logic [7:0]  REG_WDATA, REG_RDATA, RX_DATA, TX_DATA;
   logic [1:0]  TYPE_A_CUSTOM;
   logic        go, bpsk, end_valid;
   logic [7:0]  half, per;
   logic [15:0] bits;
   logic [4:0]  nbits;
   logic [7:0]  rxq[$];
   int          n_mismatch, n_tests, n_start, n_end, n_pop, cycles;
   localparam logic [5:0] ADRS [6] = '{ADDR_IO_ONE, ADDR_IO_TWO,
      ADDR_OP_CTRL, ADDR_MODE_DEF, ADDR_TYPE_A, ADDR_STREAM_OPT};
   localparam logic [7:0] RSTV [6] = '{RST_IO_ONE, RST_IO_TWO,
      RST_OP_CTRL, RST_MODE_DEF, RST_TYPE_A, RST_STREAM_OPT};

   rf_stream_mode_framer uut (.CLK_SYS(CLK_SYS), .RST(RST),
      .REG_ADDR(REG_ADDR), .REG_WE(REG_WE), .REG_WDATA(REG_WDATA),
      .REG_RDATA(REG_RDATA), .CMD_SET_DEFAULT(CMD_SET_DEFAULT),
      .CMD_TX_NOCRC(CMD_TX_NOCRC), .CMD_TX_CRC(CMD_TX_CRC),
      .SUBC_IN(SUBC_IN), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
      .RX_START(RX_START), .RX_END(RX_END), .TX_DATA(TX_DATA),
      .TX_AVAIL(TX_AVAIL), .TX_POP(TX_POP), .TX_MOD(TX_MOD),
      .TX_OOK(TX_OOK), .TYPE_A_CUSTOM(TYPE_A_CUSTOM));

   rf_tag_model tag (.clk(CLK_SYS), .go(go), .bpsk(bpsk), .half(half),
      .per(per), .bits(bits), .nbits(nbits), .subc(SUBC_IN));

   // ==========================================================
   // Clock, monitor and hang guard
   initial begin
      CLK_SYS = 1'b0;
      forever #5 CLK_SYS = ~CLK_SYS;
   end

   always @(posedge CLK_SYS) begin
      cycles++;
      if (RX_VALID === 1'b1) rxq.push_back(RX_DATA);
      if (RX_START === 1'b1) n_start++;
      if (RX_END === 1'b1) begin
         n_end++;
         end_valid = RX_VALID;
      end
      if (TX_POP === 1'b1) n_pop++;
      // All scenarios need well under half of this
      if (cycles == 20000) begin
         n_mismatch++;
         summarize();
      end
   end

   // ==========================================================
   // Shared tasks, entered just after a falling edge except summarize from the hang guard
   task check(input string what, input logic [7:0] exp,
              input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task reg_wr(input logic [5:0] a, input logic [7:0] d);
      REG_ADDR  = a;
      REG_WDATA = d;
      REG_WE    = 1'b1;
      @(negedge CLK_SYS);
      REG_WE    = 1'b0;
      // One idle edge so back-to-back writes never retoggle the strobe
      @(negedge CLK_SYS);
   endtask : reg_wr

   task reg_rd(input logic [5:0] a, input logic [7:0] exp);
      REG_ADDR = a;
      repeat (2) @(negedge CLK_SYS);
      check($sformatf("register %h", a), exp, REG_RDATA);
   endtask : reg_rd

   task summarize;
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize

   // ==========================================================
   // Scenarios
   task test_regs;
      int i;
      for (i = 0; i < 6; i++) reg_rd(ADRS[i], RSTV[i]);
      for (i = 0; i < 6; i++) reg_wr(ADRS[i], 8'hC0 | i[7:0]);
      for (i = 0; i < 6; i++) reg_rd(ADRS[i], 8'hC0 | i[7:0]);
      check("type a custom", 8'h03, {6'h00, TYPE_A_CUSTOM});
      check("ook select", 8'h01, {7'h00, TX_OOK});
      reg_wr(ADDR_STATUS, 8'hFF);
      reg_rd(ADDR_STATUS, 8'h00);
      reg_wr(6'h3F, 8'hFF);
      reg_rd(6'h3F, 8'h00);
      CMD_SET_DEFAULT = 1'b1;
      @(negedge CLK_SYS);
      CMD_SET_DEFAULT = 1'b0;
      for (i = 0; i < 6; i++)
         reg_rd(ADRS[i], i < 3 ? 8'hC0 | i[7:0] : RSTV[i]);
      check("type a custom", 8'h00, {6'h00, TYPE_A_CUSTOM});
   endtask : test_regs

   task test_tx(input logic [2:0] stx, input logic crc,
                input logic [7:0] d, input logic ook);
      int i;
      int k;
      int p;
      p = 128 >> stx;
      reg_wr(ADDR_OP_CTRL, 8'h00);
      reg_wr(ADDR_STREAM_OPT, {ook, 4'h0, stx});
      reg_wr(ADDR_MODE_DEF, {1'b0, OM_SUBC, 3'b000});
      n_pop    = 0;
      TX_DATA  = d;
      TX_AVAIL = 1'b1;
      if (crc) CMD_TX_CRC = 1'b1;
      else CMD_TX_NOCRC = 1'b1;
      @(negedge CLK_SYS);
      CMD_TX_CRC   = 1'b0;
      CMD_TX_NOCRC = 1'b0;
      for (i = 0; i < 20 && TX_POP !== 1'b1; i++) @(negedge CLK_SYS);
      TX_AVAIL = 1'b0;
      for (k = 0; k < 8; k++) begin
         repeat (p / 2) @(negedge CLK_SYS);
         check("tx bit", {7'h00, d[k]}, {7'h00, TX_MOD});
         repeat (p - p / 2) @(negedge CLK_SYS);
      end
      repeat (4) @(negedge CLK_SYS);
      check("tx idle", 8'h00, {7'h00, TX_MOD});
      check("tx pops", 8'h01, n_pop[7:0]);
      check("tx ook", {7'h00, ook}, {7'h00, TX_OOK});
   endtask : test_tx

   task test_tx_refused;
      reg_wr(ADDR_MODE_DEF, 8'h00);
      n_pop        = 0;
      TX_AVAIL     = 1'b1;
      CMD_TX_NOCRC = 1'b1;
      @(negedge CLK_SYS);
      CMD_TX_NOCRC = 1'b0;
      repeat (40) @(negedge CLK_SYS);
      check("refused pops", 8'h00, n_pop[7:0]);
      TX_AVAIL = 1'b0;
   endtask : test_tx_refused

   task rx_run(input logic b, input logic [7:0] opt, input logic [7:0] hf,
               input logic [7:0] pr, input logic [15:0] pat,
               input logic [4:0] nb);
      int i;
      rxq.delete();
      n_start   = 0;
      n_end     = 0;
      end_valid = 1'b0;
      bpsk      = b;
      half      = hf;
      per       = pr;
      bits      = pat;
      nbits     = nb;
      reg_wr(ADDR_OP_CTRL, 8'h00);
      reg_wr(ADDR_STREAM_OPT, opt);
      reg_wr(ADDR_MODE_DEF, {1'b0, b ? OM_BPSK : OM_SUBC, 3'b000});
      // Tag launched early so its periods line up with the receiver's
      go = 1'b1;
      @(negedge CLK_SYS);
      go = 1'b0;
      @(negedge CLK_SYS);
      reg_wr(ADDR_OP_CTRL, 8'h40);
      for (i = 0; i < 8000 && n_end == 0; i++) @(negedge CLK_SYS);
      repeat (4) @(negedge CLK_SYS);
      check("rx starts", 8'h01, n_start[7:0]);
      check("rx ends", 8'h01, n_end[7:0]);
      check("end with byte", 8'h01, {7'h00, end_valid});
   endtask : rx_run

   task test_sub;
      rx_run(1'b0, 8'h30, 8'd16, 8'd128, 16'h0201, 5'd10);
      check("sub bytes", 8'h03, 8'(rxq.size()));
      if (rxq.size() == 3) begin
         check("sub byte 0", 8'h01, rxq[0]);
         check("sub byte 1", 8'h02, rxq[1]);
         check("sub byte 2", 8'h00, rxq[2]);
      end
   endtask : test_sub

   task test_bpsk;
      rx_run(1'b1, 8'h08, 8'd8, 8'd32, 16'h0016, 5'd5);
      check("bpsk bytes", 8'h01, 8'(rxq.size()));
      if (rxq.size() == 1)
         check("bpsk byte", 8'h16, rxq[0]);
   endtask : test_bpsk

   // ==========================================================
   // Main sequence
   initial begin
      {RST, REG_WE, CMD_SET_DEFAULT, CMD_TX_NOCRC, CMD_TX_CRC} = 5'h10;
      {REG_ADDR, REG_WDATA, TX_DATA, TX_AVAIL, go} = 24'h000000;
      {bpsk, half, per, bits, nbits} = 38'h0;
      {n_mismatch, n_tests, n_start, n_end, n_pop, cycles} = '0;
      end_valid = 1'b0;
      repeat (2) @(negedge CLK_SYS);
      RST = 1'b0;
      @(negedge CLK_SYS);
      test_regs;
      test_tx_refused;
      test_tx(3'd0, 1'b0, 8'h5A, 1'b1);
      test_tx(3'd3, 1'b1, 8'hC3, 1'b0);
      test_sub;
      test_bpsk;
      summarize();
   end
endmodule : rf_stream_mode_framer_bench
